//--- gdfs_pkg.sv
// Package: shared constants for the gate drive fault supervisor
package gdfs_pkg;
  // --------------------------------------------------------------------------
  // Timing
  // --------------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int DEAD_HL_NS = 150;
  localparam int DEAD_LH_NS = 135;
  // Least times round up
  localparam int DEAD_HL_CYC = (DEAD_HL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DEAD_LH_CYC = (DEAD_LH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // --------------------------------------------------------------------------
  // Setpoint code
  // --------------------------------------------------------------------------
  localparam int CODE_W = 5;
  localparam int RANGE_BIT = 4;
  localparam logic [3:0] LOW_DISABLE_MIN = 4'h6;
  localparam logic [CODE_W-1:0] CODE_NO_CPU = 5'h1f;
  localparam int DUTY_W = 8;
  // Drive state machine
  typedef enum logic [3:0] {
    GDFS_OFF = 4'h1,
    GDFS_HIGH = 4'h2,
    GDFS_DEAD = 4'h4,
    GDFS_LOW = 4'h8
  } gdfs_state_t;
endpackage

//--- gdfs_sync.sv
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module gdfs_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic clk_en_i,
  // Data
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_q;
  always_comb begin
    next_meta = clk_en_i ? d_i : meta;
    next_q = clk_en_i ? meta : q_o;
  end
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      meta <= RST_VAL;
      q_o <= RST_VAL;
    end else begin
      meta <= next_meta;
      q_o <= next_q;
    end
  end
endmodule

//--- gdfs_pwm.sv
// Free running PWM ramp comparing against the duty command
`timescale 1ns/1ps
module gdfs_pwm #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic clk_en_i,
  // Duty
  input wire logic [W-1:0] duty_i,
  input wire logic [W-1:0] duty_min_i,
  input wire logic [W-1:0] duty_max_i,
  output logic high_req_o
);
  logic [W-1:0] ramp;
  logic [W-1:0] next_ramp;
  logic next_req;
  always_comb begin
    next_ramp = clk_en_i ? ramp + 1'b1 : ramp;
    // Below min is zero duty, at or above max is full duty
    if (duty_i < duty_min_i) begin
      next_req = 1'b0;
    end else if (duty_i >= duty_max_i) begin
      next_req = 1'b1;
    end else begin
      next_req = ramp < duty_i;
    end
    if (!clk_en_i) begin
      next_req = high_req_o;
    end
  end
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ramp <= '0;
      high_req_o <= 1'b0;
    end else begin
      ramp <= next_ramp;
      high_req_o <= next_req;
    end
  end
endmodule

//--- gdfs_top.sv
// Top: gate drive sequencing with dead times and fault supervision
`timescale 1ns/1ps
module gdfs_top #(
  parameter bit ALT_VARIANT = 1'b0,
  parameter int DUTY_W = gdfs_pkg::DUTY_W,
  parameter int DEAD_HL = gdfs_pkg::DEAD_HL_CYC,
  parameter int DEAD_LH = gdfs_pkg::DEAD_LH_CYC,
  parameter logic [DUTY_W-1:0] DUTY_MIN = 8'h2a,
  parameter logic [DUTY_W-1:0] DUTY_MAX = 8'hd5,
  parameter logic [DUTY_W-1:0] DUTY_CLAMP = 8'h80
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic clk_en_i,
  // Pin inputs
  input wire logic output_enable_i,
  input wire logic [gdfs_pkg::CODE_W-1:0] setpoint_code_bits_i,
  input wire logic supply_lockout_i,
  input wire logic overvoltage_trip_i,
  input wire logic window_high_i,
  input wire logic window_low_i,
  input wire logic loop_clamp_i,
  // Duty command
  input wire logic [DUTY_W-1:0] duty_command_i,
  // Drives
  output logic high_side_drive_o,
  output logic low_side_drive_o,
  // Open-drain power good
  output logic power_good_out_o,
  output logic power_good_oe_o
);
  // --------------------------------------------------------------------------
  // Input synchronisers
  // --------------------------------------------------------------------------
  localparam int NSYNC = gdfs_pkg::CODE_W + 6;
  logic [NSYNC-1:0] raw;
  logic [NSYNC-1:0] syn;
  assign raw = {setpoint_code_bits_i, output_enable_i, supply_lockout_i, overvoltage_trip_i,
                window_high_i, window_low_i, loop_clamp_i};
  // Lockout resets high so drives stay off until it is seen released
  gdfs_sync #(
    .W(NSYNC),
    .RST_VAL({{gdfs_pkg::CODE_W{1'b1}}, 1'b0, 1'b1, 4'h0})
  ) u_sync (
    .clock_i(clock_i),
    .arst_n_i(arst_n_i),
    .clk_en_i(clk_en_i),
    .d_i(raw),
    .q_o(syn)
  );
  logic [gdfs_pkg::CODE_W-1:0] code;
  logic en_s;
  logic lockout_s;
  logic ovp_s;
  logic win_hi_s;
  logic win_lo_s;
  logic clamp_s;
  assign {code, en_s, lockout_s, ovp_s, win_hi_s, win_lo_s, clamp_s} = syn;
  // --------------------------------------------------------------------------
  // Setpoint decode
  // --------------------------------------------------------------------------
  logic code_disable;
  logic [3:0] code_mag;
  always_comb begin
    code_mag = code[3:0];
    // Low range: 4'hf is 1.30 V, descending to 4'h6 at 1.75 V
    code_disable = (!code[gdfs_pkg::RANGE_BIT] && code_mag >= gdfs_pkg::LOW_DISABLE_MIN)
                   || (code == gdfs_pkg::CODE_NO_CPU);
    if (ALT_VARIANT) begin
      code_disable = 1'b0;
    end
  end
  // --------------------------------------------------------------------------
  // Duty request
  // --------------------------------------------------------------------------
  logic [DUTY_W-1:0] duty_eff;
  logic high_req;
  // Clamp caps the command; limits duty the way current limit would
  assign duty_eff = (clamp_s && duty_command_i > DUTY_CLAMP) ? DUTY_CLAMP : duty_command_i;
  gdfs_pwm #(
    .W(DUTY_W)
  ) u_pwm (
    .clock_i(clock_i),
    .arst_n_i(arst_n_i),
    .clk_en_i(clk_en_i),
    .duty_i(duty_eff),
    .duty_min_i(DUTY_MIN),
    .duty_max_i(DUTY_MAX),
    .high_req_o(high_req)
  );
  // --------------------------------------------------------------------------
  // Drive sequencer
  // --------------------------------------------------------------------------
  localparam int CW = 16;
  logic all_off;
  logic want_high;
  gdfs_pkg::gdfs_state_t state;
  gdfs_pkg::gdfs_state_t next_state;
  logic dead_to_low;
  logic next_dead_to_low;
  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;
  logic next_hi;
  logic next_lo;
  assign all_off = lockout_s || !en_s || code_disable;
  assign want_high = high_req && !ovp_s;
  always_comb begin
    next_state = state;
    next_dead_to_low = dead_to_low;
    next_cnt = cnt;
    if (cnt != '0) begin
      next_cnt = cnt - 1'b1;
    end
    unique case (state)
      gdfs_pkg::GDFS_OFF: begin
        if (!all_off) begin
          // Start with the dead gap for the side asked for so neither drive follows the other without dead time
          next_state = gdfs_pkg::GDFS_DEAD;
          next_dead_to_low = !want_high;
          next_cnt = want_high ? CW'(DEAD_LH) : CW'(DEAD_HL);
        end
      end
      gdfs_pkg::GDFS_HIGH: begin
        if (all_off) begin
          next_state = gdfs_pkg::GDFS_OFF;
        end else if (!want_high) begin
          next_state = gdfs_pkg::GDFS_DEAD;
          next_dead_to_low = 1'b1;
          next_cnt = CW'(DEAD_HL);
        end
      end
      gdfs_pkg::GDFS_LOW: begin
        if (all_off) begin
          next_state = gdfs_pkg::GDFS_OFF;
        end else if (want_high) begin
          next_state = gdfs_pkg::GDFS_DEAD;
          next_dead_to_low = 1'b0;
          next_cnt = CW'(DEAD_LH);
        end
      end
      gdfs_pkg::GDFS_DEAD: begin
        if (all_off) begin
          next_state = gdfs_pkg::GDFS_OFF;
        end else if (cnt <= CW'(1)) begin
          // Request flipped during the gap: restart the dead gap toward the side now asked for
          next_state = want_high ? gdfs_pkg::GDFS_HIGH : gdfs_pkg::GDFS_LOW;
          if (want_high == dead_to_low) begin
            next_state = gdfs_pkg::GDFS_DEAD;
            next_dead_to_low = !want_high;
            next_cnt = want_high ? CW'(DEAD_LH) : CW'(DEAD_HL);
          end
        end
      end
      default: begin
        next_state = gdfs_pkg::GDFS_OFF;
      end
    endcase
    if (!clk_en_i) begin
      next_state = state;
      next_dead_to_low = dead_to_low;
      next_cnt = cnt;
    end
    next_hi = next_state == gdfs_pkg::GDFS_HIGH;
    next_lo = next_state == gdfs_pkg::GDFS_LOW;
  end
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state <= gdfs_pkg::GDFS_OFF;
      dead_to_low <= 1'b0;
      cnt <= '0;
      high_side_drive_o <= 1'b0;
      low_side_drive_o <= 1'b0;
    end else begin
      state <= next_state;
      dead_to_low <= next_dead_to_low;
      cnt <= next_cnt;
      high_side_drive_o <= next_hi;
      low_side_drive_o <= next_lo;
    end
  end
  // --------------------------------------------------------------------------
  // Power good
  // --------------------------------------------------------------------------
  logic next_pg_oe;
  always_comb begin
    // Pulled low out of window or in lockout
    next_pg_oe = clk_en_i ? (win_hi_s || win_lo_s || lockout_s) : power_good_oe_o;
  end
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      power_good_oe_o <= 1'b1;
    end else begin
      power_good_oe_o <= next_pg_oe;
    end
  end
  assign power_good_out_o = 1'b0;
endmodule

//--- gdfs_props.sv
// Checker: gate drive sequencing and fault supervision properties
`timescale 1ns/1ps
module gdfs_props #(
  parameter bit ALT_VARIANT = 1'b0,
  parameter int DUTY_W = 8,
  parameter int DEAD_HL = 15,
  parameter int DEAD_LH = 14,
  parameter logic [DUTY_W-1:0] DUTY_MIN = 8'h2a
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic clk_en_i,
  // Pins
  input wire logic output_enable_i,
  input wire logic [gdfs_pkg::CODE_W-1:0] setpoint_code_bits_i,
  input wire logic supply_lockout_i,
  input wire logic overvoltage_trip_i,
  input wire logic window_high_i,
  input wire logic window_low_i,
  input wire logic [DUTY_W-1:0] duty_command_i,
  // Outputs
  input wire logic high_side_drive_o,
  input wire logic low_side_drive_o,
  input wire logic power_good_out_o,
  input wire logic power_good_oe_o
);
  logic [7:0] hi_gap;
  logic [7:0] lo_gap;
  logic code_off;
  assign code_off = !ALT_VARIANT && (setpoint_code_bits_i == 5'h1f ||
    (!setpoint_code_bits_i[4] && setpoint_code_bits_i[3:0] >= 4'h6));
  // Saturating counts of cycles since each drive was last seen high
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      hi_gap <= 8'hff;
      lo_gap <= 8'hff;
    end else begin
      hi_gap <= high_side_drive_o ? 8'h00 : hi_gap + 8'(hi_gap != 8'hff);
      lo_gap <= low_side_drive_o ? 8'h00 : lo_gap + 8'(lo_gap != 8'hff);
    end
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);
  a_no_overlap: assert property (!(high_side_drive_o && low_side_drive_o))
    else $error("both drives high together");
  a_dead_hl: assert property ($rose(low_side_drive_o) |-> hi_gap >= DEAD_HL)
    else $error("low side on too soon");
  a_dead_lh: assert property ($rose(high_side_drive_o) |-> lo_gap >= DEAD_LH)
    else $error("high side on too soon");
  a_lockout_off: assert property ((supply_lockout_i && clk_en_i) [*5] |->
    !high_side_drive_o && !low_side_drive_o)
    else $error("drive on in lockout");
  a_enable_off: assert property ((!output_enable_i && clk_en_i) [*5] |->
    !high_side_drive_o && !low_side_drive_o)
    else $error("drive on while disabled");
  a_pg_window: assert property (((window_high_i || window_low_i || supply_lockout_i) && clk_en_i) [*5] |->
    power_good_oe_o && !power_good_out_o)
    else $error("power good not pulled low");
  a_ovp_high_off: assert property ((overvoltage_trip_i && clk_en_i) [*5] |-> !high_side_drive_o)
    else $error("high side on in overvoltage");
  a_code_off: assert property ((code_off && clk_en_i) [*5] |->
    !high_side_drive_o && !low_side_drive_o)
    else $error("drive on with disabling code");
  a_zero_duty: assert property ((duty_command_i < DUTY_MIN && clk_en_i) [*5] |-> !high_side_drive_o)
    else $error("high side on below minimum duty");
  c_low_on: cover property ($rose(low_side_drive_o));
  c_high_on: cover property ($rose(high_side_drive_o));
  c_pg_low: cover property ($rose(power_good_oe_o));
endmodule

//--- gdfs_fet_model.sv
// Partner: external switch pair, records overlap and dead gaps
`timescale 1ns/1ps
module gdfs_fet_model (
  // Clock and reset
  input wire logic clock_i,
  input wire logic arst_n_i,
  // Gate drives
  input wire logic high_side_drive_i,
  input wire logic low_side_drive_i,
  // Observations
  output logic shoot_o,
  output logic [7:0] min_hl_o,
  output logic [7:0] min_lh_o
);
  logic [7:0] gap;
  logic last_hi;
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      gap <= 8'hff;
      last_hi <= 1'b0;
      shoot_o <= 1'b0;
      min_hl_o <= 8'hff;
      min_lh_o <= 8'hff;
    end else begin
      // Both on means cross conduction in the real pair
      shoot_o <= shoot_o | (high_side_drive_i & low_side_drive_i);
      if (high_side_drive_i || low_side_drive_i) begin
        gap <= 8'h00;
        last_hi <= high_side_drive_i;
        if (high_side_drive_i && !last_hi && gap < min_lh_o) min_lh_o <= gap;
        if (low_side_drive_i && last_hi && gap < min_hl_o) min_hl_o <= gap;
      end else begin
        gap <= gap + 8'(gap != 8'hff);
      end
    end
  end
endmodule

//--- gdfs_tb_top.sv
// Testbench: drives pin levels and duty, checks drives and power good
`timescale 1ns/1ps
module gdfs_tb_top;
  localparam int DHL = 4;
  localparam int DLH = 3;
  logic clock_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic clk_en_i = 1'b1;
  // Pull-ups modelled as idle high on enable and code pins
  logic output_enable_i = 1'b1;
  logic [4:0] code = 5'h1f;
  logic lockout = 1'b0, overvoltage_trip = 1'b0, win_hi = 1'b0, win_lo = 1'b0, clamp = 1'b0;
  logic [7:0] duty = 8'hff;
  logic hi, lo, pg, pg_oe, hi_alt, lo_alt, shoot, seen, off;
  logic [1:0] h;
  logic [7:0] min_hl, min_lh;
  int errors = 0;
  int comparisons = 0;
  int cycles = 0;
  always #5 clock_i = ~clock_i;
  gdfs_top #(.DEAD_HL(DHL), .DEAD_LH(DLH)) gdfs_top_i (.clock_i(clock_i), .arst_n_i(arst_n_i),
    .clk_en_i(clk_en_i), .output_enable_i(output_enable_i), .setpoint_code_bits_i(code),
    .supply_lockout_i(lockout), .overvoltage_trip_i(overvoltage_trip), .window_high_i(win_hi), .window_low_i(win_lo),
    .loop_clamp_i(clamp), .duty_command_i(duty), .high_side_drive_o(hi), .low_side_drive_o(lo),
    .power_good_out_o(pg), .power_good_oe_o(pg_oe));
  gdfs_top #(.ALT_VARIANT(1'b1), .DEAD_HL(DHL), .DEAD_LH(DLH)) gdfs_top_alt_i (.clock_i(clock_i),
    .arst_n_i(arst_n_i), .clk_en_i(clk_en_i), .output_enable_i(output_enable_i), .setpoint_code_bits_i(code),
    .supply_lockout_i(lockout), .overvoltage_trip_i(overvoltage_trip), .window_high_i(win_hi), .window_low_i(win_lo),
    .loop_clamp_i(clamp), .duty_command_i(duty), .high_side_drive_o(hi_alt), .low_side_drive_o(lo_alt),
    .power_good_out_o(), .power_good_oe_o());
  gdfs_fet_model gdfs_fet_model_i (.clock_i(clock_i), .arst_n_i(arst_n_i), .high_side_drive_i(hi),
    .low_side_drive_i(lo), .shoot_o(shoot), .min_hl_o(min_hl), .min_lh_o(min_lh));
  // Flags f: enable, lockout, overvoltage, window high, window low, clamp
  task automatic apply(input logic [4:0] c, input logic [7:0] d, input logic [5:0] f);
    @(posedge clock_i);
    code <= c;
    duty <= d;
    {output_enable_i, lockout, overvoltage_trip, win_hi, win_lo, clamp} <= f;
    repeat (40) @(posedge clock_i);
    @(negedge clock_i);
  endtask
  task automatic check(input string what, input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic give_verdict();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 10000) begin
      errors++;
      give_verdict();
    end
  end
  initial begin
    repeat (5) @(posedge clock_i);
    arst_n_i <= 1'b1;
    apply(5'h00, 8'hff, 6'h20);
    check("full duty", 8'({hi, lo}), 8'h2);
    check("power good", 8'({pg, pg_oe}), 8'h0);
    apply(5'h00, 8'h00, 6'h20);
    check("zero duty", 8'({hi, lo}), 8'h1);
    apply(5'h00, 8'h80, 6'h20);
    repeat (600) @(negedge clock_i);
    check("overlap", 8'(shoot), 8'h0);
    check("dead hl", 8'(min_hl >= DHL && min_hl != 8'hff), 8'h1);
    check("dead lh", 8'(min_lh >= DLH && min_lh != 8'hff), 8'h1);
    @(posedge clock_i);
    clk_en_i <= 1'b0;
    repeat (3) @(negedge clock_i);
    h = {hi, lo};
    repeat (300) @(negedge clock_i);
    check("frozen", 8'({hi, lo}), 8'(h));
    @(posedge clock_i);
    clk_en_i <= 1'b1;
    apply(5'h00, 8'hff, 6'h21);
    seen = 1'b0;
    repeat (300) begin
      @(negedge clock_i);
      seen |= lo;
    end
    check("clamp", 8'(seen), 8'h1);
    apply(5'h00, 8'hff, 6'h28);
    check("overvoltage", 8'({hi, lo}), 8'h1);
    apply(5'h00, 8'hff, 6'h24);
    check("window high", 8'(pg_oe), 8'h1);
    apply(5'h00, 8'hff, 6'h22);
    check("window low", 8'(pg_oe), 8'h1);
    apply(5'h00, 8'hff, 6'h00);
    check("disabled", 8'({hi, lo}), 8'h0);
    apply(5'h00, 8'hff, 6'h30);
    check("lockout", 8'({hi, lo, pg_oe}), 8'h1);
    for (int c = 0; c < 32; c++) begin
      apply(5'(c), 8'h00, 6'h20);
      off = (c == 31) || (c < 16 && c >= 6);
      check("code", 8'({hi, lo}), 8'(!off));
      check("alt code", 8'({hi_alt, lo_alt}), 8'h1);
    end
    give_verdict();
  end
endmodule
bind gdfs_top gdfs_props #(.ALT_VARIANT(ALT_VARIANT), .DUTY_W(DUTY_W), .DEAD_HL(DEAD_HL),
  .DEAD_LH(DEAD_LH), .DUTY_MIN(DUTY_MIN)) gdfs_props_i (.clock_i(clock_i), .arst_n_i(arst_n_i),
  .clk_en_i(clk_en_i), .output_enable_i(output_enable_i), .setpoint_code_bits_i(setpoint_code_bits_i),
  .supply_lockout_i(supply_lockout_i), .overvoltage_trip_i(overvoltage_trip_i), .window_high_i(window_high_i),
  .window_low_i(window_low_i), .duty_command_i(duty_command_i), .high_side_drive_o(high_side_drive_o),
  .low_side_drive_o(low_side_drive_o), .power_good_out_o(power_good_out_o), .power_good_oe_o(power_good_oe_o));
